// ===== pkg/ring_regs.svh
// register offsets, field positions, reset values and timing counts of the ring role block
`ifndef RING_REGS_SVH
`define RING_REGS_SVH
`define RR_CTRL             8'h00
`define RR_PORTS            8'h04
`define RR_MAC_LO           8'h08
`define RR_MAC_HI           8'h0c
`define RR_MANUAL           8'h10
`define RR_STATUS           8'h14
`define RR_BLOCK            8'h18
`define RR_CTRL_RING_EN     0
`define RR_CTRL_MODE_LSB    1
`define RR_CTRL_OBS_EN      4
`define RR_CTRL_OBS_RESTART 5
`define RR_CTRL_STP_EN      6
`define RR_CTRL_SB_EN       8
`define RR_CTRL_SB_FORCE    9
`define RR_PORTS_A_LSB      0
`define RR_PORTS_B_LSB      8
`define RR_PORTS_SB_LSB     16
`define RR_ST_ROLE_LSB      0
`define RR_ST_NEGO_DONE     3
`define RR_ST_OBS_BLOCK     4
`define RR_ST_OBS_LATCHED   5
`define RR_ST_SB_MASTER     6
`define RR_ST_SB_PORT_EN    7
`define RR_CTRL_RST         10'h040
`define RR_PORT_A_RST       5'h00
`define RR_PORT_B_RST       5'h01
`define RR_PORT_SB_RST      5'h02
`define RR_CLK_KHZ          20000
`define RR_NEGO_MS          100
`define RR_NEGO_CYC         (`RR_NEGO_MS * `RR_CLK_KHZ)
`define RR_OBS_WIN_MS       500
`define RR_OBS_WIN_CYC      (`RR_OBS_WIN_MS * `RR_CLK_KHZ)
`define RR_OBS_ERR_LIMIT    5
`endif

// ===== pkg/ring_pkg.sv
// types and helpers of the ring role block
`default_nettype none
package ring_pkg;
  typedef enum logic [2:0] {
    mode_auto, mode_mrp_auto, mode_mrp_client, mode_propr_client, mode_propr_manager
  } ring_mode_t;
  typedef enum logic [2:0] {
    role_off, role_mrp_client, role_mrp_manager, role_propr_client, role_propr_manager
  } ring_role_t;
  typedef logic [47:0] mac_t;

  // first transmitted octet sits in bits 47:40, so plain unsigned compare
  function automatic logic mac_below(input mac_t a, input mac_t b);
    return a < b;
  endfunction : mac_below

  function automatic logic is_propr(input ring_role_t r);
    return (r == role_propr_client) || (r == role_propr_manager);
  endfunction : is_propr

  function automatic logic is_manager(input ring_role_t r);
    return (r == role_mrp_manager) || (r == role_propr_manager);
  endfunction : is_manager
endpackage : ring_pkg
`default_nettype wire

// ===== pkg/ring_ctl_if.sv
// control carrier between the ring role top and its negotiator and observer
`timescale 1ns/1ps
`default_nettype none
interface ring_ctl_if;
  logic                ce;
  logic                nego_run;
  logic                nego_detect;
  ring_pkg::mac_t      own_mac;
  ring_pkg::ring_role_t nego_role;
  logic                nego_done;
  logic                obs_run;
  logic                obs_fault;
  logic                obs_restart;
  logic                obs_block;
  logic                obs_latched;
  logic                obs_msg;
  modport ctl  (output ce, nego_run, nego_detect, own_mac, obs_run, obs_fault, obs_restart,
                input nego_role, nego_done, obs_block, obs_latched, obs_msg);
  modport nego (input ce, nego_run, nego_detect, own_mac, output nego_role, nego_done);
  modport obs  (input ce, obs_run, obs_fault, obs_restart,
                output obs_block, obs_latched, obs_msg);
endinterface : ring_ctl_if
`default_nettype wire

// ===== rtl/ring_role_negotiator.sv
// lowest-address manager negotiation and proprietary manager detection
`timescale 1ns/1ps
`default_nettype none
`include "ring_regs.svh"
module ring_role_negotiator #(
  parameter int unsigned NEGO_CYC = `RR_NEGO_CYC
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  ring_ctl_if.nego            ctl,
  input  wire ring_pkg::mac_t peer_mac_i,
  input  wire logic           peer_vld_i,
  input  wire logic           mgr_seen_i
);
  logic [31:0] timer_q;
  logic        done_q;
  logic        lower_q;
  logic        mgr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_q <= 32'h0000_0000;
      done_q  <= 1'b0;
    end else if (ctl.ce) begin
      if (!ctl.nego_run) begin
        timer_q <= 32'h0000_0000;
        done_q  <= 1'b0;
      end else if (!done_q) begin
        if (timer_q == 32'(NEGO_CYC - 1)) done_q <= 1'b1;
        else timer_q <= timer_q + 32'h0000_0001;
      end
    end
  end

  // a lower peer keeps demoting us even after the window closed
  always_ff @(posedge clk_i) begin
    if (rst_i) lower_q <= 1'b0;
    else if (ctl.ce) begin
      if (!ctl.nego_run) lower_q <= 1'b0;
      else if (peer_vld_i && ring_pkg::mac_below(peer_mac_i, ctl.own_mac)) lower_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) mgr_q <= 1'b0;
    else if (ctl.ce) begin
      if (!ctl.nego_run) mgr_q <= 1'b0;
      else if (ctl.nego_detect && mgr_seen_i) mgr_q <= 1'b1;
    end
  end

  assign ctl.nego_done = done_q;
  assign ctl.nego_role = !ctl.nego_run ? ring_pkg::role_off :
                         mgr_q         ? ring_pkg::role_propr_client :
                         !done_q       ? ring_pkg::role_off :
                         lower_q       ? ring_pkg::role_mrp_client :
                                         ring_pkg::role_mrp_manager;
endmodule : ring_role_negotiator
`default_nettype wire

// ===== rtl/ring_observer.sv
// ring observer: blocks a ring port on faults and latches after an error burst
`timescale 1ns/1ps
`default_nettype none
`include "ring_regs.svh"
module ring_observer #(
  parameter int unsigned WIN_CYC   = `RR_OBS_WIN_CYC,
  parameter int unsigned ERR_LIMIT = `RR_OBS_ERR_LIMIT
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ring_ctl_if.obs   ctl
);
  logic        fault_q;
  logic [7:0]  err_q;
  logic [31:0] win_q;
  logic        latched_q;
  logic        msg_q;
  logic        new_err;

  assign new_err = ctl.obs_run && ctl.obs_fault && !fault_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) fault_q <= 1'b0;
    else if (ctl.ce) fault_q <= ctl.obs_fault;
  end

  // errors count inside a sliding-free window that restarts when it empties
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 8'h00;
      win_q <= 32'h0000_0000;
    end else if (ctl.ce) begin
      if (ctl.obs_restart) begin
        err_q <= 8'h00;
        win_q <= 32'h0000_0000;
      end else if (new_err) begin
        if (err_q != 8'hff) err_q <= err_q + 8'h01;
      end else if (err_q != 8'h00) begin
        if (win_q == 32'(WIN_CYC - 1)) begin
          err_q <= 8'h00;
          win_q <= 32'h0000_0000;
        end else win_q <= win_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_q <= 1'b0;
      msg_q     <= 1'b0;
    end else if (ctl.ce) begin
      msg_q <= 1'b0;
      if (new_err && !latched_q && (err_q + 8'h01 >= 8'(ERR_LIMIT))) begin
        latched_q <= 1'b1;
        msg_q     <= 1'b1;
      end else if (ctl.obs_restart) latched_q <= 1'b0;
    end
  end

  assign ctl.obs_block   = ctl.obs_run && (ctl.obs_fault || latched_q);
  assign ctl.obs_latched = latched_q;
  assign ctl.obs_msg     = msg_q;
endmodule : ring_observer
`default_nettype wire

// ===== rtl/ring_redundancy_role_control.sv
// ring redundancy role, ring port state, observer and standby control
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ring_regs.svh"
module ring_redundancy_role_control #(
  parameter int unsigned N_PORTS   = 24,
  parameter int unsigned NEGO_CYC  = `RR_NEGO_CYC,
  parameter int unsigned OBS_WIN   = `RR_OBS_WIN_CYC,
  parameter int unsigned ERR_LIMIT = `RR_OBS_ERR_LIMIT
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 we_i,
  input  wire logic                 re_i,
  output logic      [31:0]          rdata_o,
  input  wire logic                 mgr_seen_i,
  input  wire logic [47:0]          peer_mac_i,
  input  wire logic                 peer_mac_vld_i,
  input  wire logic                 obs_fault_i,
  input  wire logic                 factory_reset_i,
  input  wire logic                 variant_i,
  input  wire logic [47:0]          sb_partner_mac_i,
  input  wire logic                 sb_partner_force_i,
  input  wire logic                 sb_partner_fail_i,
  input  wire logic                 sb_link_ok_i,
  output logic      [N_PORTS-1:0]   port_block_o,
  output logic      [N_PORTS-1:0]   ring_port_mask_o,
  output logic      [2:0]           role_o,
  output logic                      stp_en_o,
  output logic                      sb_master_o,
  output logic                      sb_port_en_o,
  output logic                      err_led_o,
  output logic                      msg_o
);
  ring_ctl_if ctl ();

  logic [9:0]           ctrl_q;
  logic [4:0]           port_a_q;
  logic [4:0]           port_b_q;
  logic [4:0]           sb_sel_q;
  ring_pkg::mac_t       mac_q;
  logic [N_PORTS-1:0]   manual_q;
  logic                 restart_q;
  ring_pkg::ring_role_t role_q;
  ring_pkg::ring_role_t role_d;
  logic [N_PORTS-1:0]   block_q;
  logic [N_PORTS-1:0]   block_d;
  logic [N_PORTS-1:0]   mask_q;
  logic [N_PORTS-1:0]   mask_d;
  logic                 sb_master_q;
  logic                 sb_master_d;
  logic                 sb_port_q;
  logic                 sb_port_d;
  logic                 led_q;
  logic                 msg_q;
  logic [31:0]          rdata_q;
  logic [31:0]          rdata_d;
  logic                 ring_en;
  logic                 sb_active;
  ring_pkg::ring_mode_t mode;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return (a == ofs);
  endfunction : wr_hit

  assign ring_en = ctrl_q[`RR_CTRL_RING_EN];
  assign mode    = ring_pkg::ring_mode_t'(ctrl_q[`RR_CTRL_MODE_LSB +: 3]);

  // control register; factory reset outranks a software write
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `RR_CTRL_RST;
    end else if (ce_i) begin
      if (factory_reset_i) begin
        if (!variant_i) begin
          ctrl_q[`RR_CTRL_RING_EN] <= 1'b0;
          ctrl_q[`RR_CTRL_STP_EN]  <= 1'b1;
        end else begin
          ctrl_q[`RR_CTRL_RING_EN] <= 1'b1;
        end
      end else if (we_i && wr_hit(addr_i, `RR_CTRL)) begin
        ctrl_q <= wdata_i[9:0];
        ctrl_q[`RR_CTRL_OBS_RESTART] <= 1'b0;
        // bit 7 is reserved and reads zero whatever software writes
        ctrl_q[7] <= 1'b0;
      end
    end
  end

  // restart is a write-one pulse, not stored
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      restart_q <= 1'b0;
    end else if (ce_i) begin
      restart_q <= we_i && wr_hit(addr_i, `RR_CTRL) &&
                   wdata_i[`RR_CTRL_OBS_RESTART];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port_a_q <= `RR_PORT_A_RST;
      port_b_q <= `RR_PORT_B_RST;
      sb_sel_q <= `RR_PORT_SB_RST;
    end else if (ce_i) begin
      if (factory_reset_i) begin
        port_a_q <= `RR_PORT_A_RST;
        port_b_q <= `RR_PORT_B_RST;
        sb_sel_q <= `RR_PORT_SB_RST;
      end else if (we_i && wr_hit(addr_i, `RR_PORTS)) begin
        port_a_q <= wdata_i[`RR_PORTS_A_LSB +: 5];
        port_b_q <= wdata_i[`RR_PORTS_B_LSB +: 5];
        sb_sel_q <= wdata_i[`RR_PORTS_SB_LSB +: 5];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mac_q <= 48'h0000_0000_0000;
    end else if (ce_i) begin
      if (we_i && wr_hit(addr_i, `RR_MAC_LO)) begin
        mac_q[31:0] <= wdata_i;
      end
      // only the low half of the upper word holds address bits
      if (we_i && wr_hit(addr_i, `RR_MAC_HI)) begin
        mac_q[47:32] <= wdata_i[15:0];
      end
    end
  end

  // manual states are kept but both ring ports override them in every role while the ring is enabled
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      manual_q <= '0;
    end else if (ce_i && we_i && wr_hit(addr_i, `RR_MANUAL)) begin
      manual_q <= wdata_i[N_PORTS-1:0];
    end
  end

  // negotiation runs only in the negotiating modes, detection only in automatic
  assign ctl.ce          = ce_i;
  assign ctl.nego_run    = ring_en && (mode == ring_pkg::mode_auto ||
                                       mode == ring_pkg::mode_mrp_auto);
  assign ctl.nego_detect = (mode == ring_pkg::mode_auto);
  assign ctl.own_mac     = mac_q;
  assign ctl.obs_run     = ring_en && ctrl_q[`RR_CTRL_OBS_EN] &&
                           ring_pkg::is_propr(role_q);
  assign ctl.obs_fault   = obs_fault_i;
  assign ctl.obs_restart = restart_q;

  ring_role_negotiator #(
    .NEGO_CYC (NEGO_CYC)
  ) u_nego (
    .clk_i      (ref_clk_i),
    .rst_i      (sys_rst_i),
    .ctl        (ctl.nego),
    .peer_mac_i (peer_mac_i),
    .peer_vld_i (peer_mac_vld_i),
    .mgr_seen_i (mgr_seen_i)
  );

  ring_observer #(
    .WIN_CYC   (OBS_WIN),
    .ERR_LIMIT (ERR_LIMIT)
  ) u_obs (
    .clk_i (ref_clk_i),
    .rst_i (sys_rst_i),
    .ctl   (ctl.obs)
  );

  always_comb begin
    role_d = ring_pkg::role_off;
    if (ring_en) begin
      unique case (mode)
        ring_pkg::mode_auto,
        ring_pkg::mode_mrp_auto:      role_d = ctl.nego_role;
        ring_pkg::mode_mrp_client:    role_d = ring_pkg::role_mrp_client;
        ring_pkg::mode_propr_client:  role_d = ring_pkg::role_propr_client;
        ring_pkg::mode_propr_manager: role_d = ring_pkg::role_propr_manager;
        default:                      role_d = ring_pkg::role_off;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    // registered so ports and standby act on one settled role each cycle
    if (sys_rst_i) begin
      role_q <= ring_pkg::role_off;
    end else if (ce_i) begin
      role_q <= role_d;
    end
  end

  // standby: forced side wins, otherwise the higher address
  assign sb_active = ctrl_q[`RR_CTRL_SB_EN] && ring_en && ring_pkg::is_propr(role_q);

  always_comb begin
    if (ctrl_q[`RR_CTRL_SB_FORCE] != sb_partner_force_i) begin
      sb_master_d = ctrl_q[`RR_CTRL_SB_FORCE];
    end else begin
      sb_master_d = ring_pkg::mac_below(sb_partner_mac_i, mac_q);
    end
    if (!sb_active) begin
      sb_master_d = 1'b0;
      sb_port_d   = 1'b0;
    end else if (sb_master_d) begin
      sb_port_d = sb_link_ok_i;
    end else begin
      sb_port_d = sb_partner_fail_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sb_master_q <= 1'b0;
    end else if (ce_i) begin
      sb_master_q <= sb_master_d;
    end
  end

  // the standby port moves on the same edge as the master flag, never ahead of it
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sb_port_q <= 1'b0;
    end else if (ce_i) begin
      sb_port_q <= sb_port_d;
    end
  end

  // per-port blocking; the first ring port is the isolated one
  always_comb begin
    block_d = manual_q;
    mask_d  = '0;
    for (int p = 0; p < N_PORTS; p++) begin
      if (ring_en && (5'(p) == port_a_q)) begin
        mask_d[p]  = 1'b1;
        block_d[p] = ring_pkg::is_manager(role_q) || ctl.obs_block;
      end else if (ring_en && (5'(p) == port_b_q)) begin
        mask_d[p]  = 1'b1;
        block_d[p] = 1'b0;
      end else if (sb_active && (5'(p) == sb_sel_q)) begin
        block_d[p] = !sb_port_d;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      block_q <= '0;
    end else if (ce_i) begin
      block_q <= block_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mask_q <= '0;
    end else if (ce_i) begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      led_q <= 1'b0;
    end else if (ce_i) begin
      led_q <= ctl.obs_latched;
    end
  end

  // both sit one flop behind the observer, so message and indication rise together
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      msg_q <= 1'b0;
    end else if (ce_i) begin
      msg_q <= ctl.obs_msg;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (addr_i)
      `RR_CTRL:   rdata_d[9:0] = ctrl_q;
      `RR_PORTS: begin
        rdata_d[`RR_PORTS_A_LSB +: 5]  = port_a_q;
        rdata_d[`RR_PORTS_B_LSB +: 5]  = port_b_q;
        rdata_d[`RR_PORTS_SB_LSB +: 5] = sb_sel_q;
      end
      `RR_MAC_LO: rdata_d = mac_q[31:0];
      `RR_MAC_HI: rdata_d[15:0] = mac_q[47:32];
      `RR_MANUAL: rdata_d[N_PORTS-1:0] = manual_q;
      `RR_STATUS: begin
        rdata_d[`RR_ST_ROLE_LSB +: 3]  = role_q;
        rdata_d[`RR_ST_NEGO_DONE]      = ctl.nego_done;
        rdata_d[`RR_ST_OBS_BLOCK]      = ctl.obs_block;
        rdata_d[`RR_ST_OBS_LATCHED]    = ctl.obs_latched;
        rdata_d[`RR_ST_SB_MASTER]      = sb_master_q;
        rdata_d[`RR_ST_SB_PORT_EN]     = sb_port_q;
      end
      `RR_BLOCK:  rdata_d[N_PORTS-1:0] = block_q;
      // unmapped addresses read zero so probing software sees no alias
      default:    rdata_d = 32'h0000_0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) rdata_q <= 32'h0000_0000;
    else if (ce_i) rdata_q <= re_i ? rdata_d : 32'h0000_0000;
  end

  assign rdata_o          = rdata_q;
  assign port_block_o     = block_q;
  assign ring_port_mask_o = mask_q;
  assign role_o           = role_q;
  assign stp_en_o         = ctrl_q[`RR_CTRL_STP_EN];
  assign sb_master_o      = sb_master_q;
  assign sb_port_en_o     = sb_port_q;
  assign err_led_o        = led_q;
  assign msg_o            = msg_q;
endmodule : ring_redundancy_role_control
`default_nettype wire

// ===== tb/ring_role_props.sv
// port-level assertions of the ring role block
`timescale 1ns/1ps
`default_nettype none
module ring_role_props #(
  parameter int unsigned N_PORTS = 24
) (
  input wire logic               ref_clk_i,
  input wire logic               sys_rst_i,
  input wire logic               factory_reset_i,
  input wire logic               variant_i,
  input wire logic               sb_partner_fail_i,
  input wire logic               sb_link_ok_i,
  input wire logic [N_PORTS-1:0] port_block_o,
  input wire logic [2:0]         role_o,
  input wire logic               stp_en_o,
  input wire logic               sb_master_o,
  input wire logic               sb_port_en_o,
  input wire logic               err_led_o,
  input wire logic               msg_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  msg_single_pulse_a: assert property (msg_o |=> !msg_o)
    else $error("latch message longer than one cycle");
  msg_sets_led_a: assert property (msg_o |=> err_led_o)
    else $error("latch message without error indication");
  latched_port_blocked_a: assert property (err_led_o && $past(err_led_o) |-> port_block_o[0])
    else $error("latched observer port not blocking");
  manager_port_state_a: assert property ((role_o == 3'h4)[*2] |-> port_block_o[1:0] == 2'b01)
    else $error("manager ring ports not blocking and forwarding");
  master_forwards_a: assert property ((sb_master_o && sb_link_ok_i)[*2] |-> sb_port_en_o)
    else $error("standby master not forwarding");
  master_drops_a: assert property ((sb_master_o && !sb_link_ok_i)[*2] |-> !sb_port_en_o)
    else $error("standby master kept port on link loss");
  slave_follows_a: assert property ((!sb_master_o && role_o inside {3'h3, 3'h4})[*2]
    ##0 $stable(sb_partner_fail_i) |-> sb_port_en_o == sb_partner_fail_i)
    else $error("standby slave port does not follow partner failure");
  standby_needs_propr_a: assert property ((role_o != 3'h3 && role_o != 3'h4)[*2]
    |-> !sb_master_o && !sb_port_en_o)
    else $error("standby active outside proprietary roles");
  factory_ring_off_a: assert property (factory_reset_i && !variant_i
    |-> ##2 stp_en_o && role_o == 3'h0)
    else $error("factory reset left ring on or spanning tree off");
endmodule : ring_role_props
bind ring_redundancy_role_control ring_role_props #(.N_PORTS(N_PORTS)) u_props (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .factory_reset_i(factory_reset_i),
  .variant_i(variant_i), .sb_partner_fail_i(sb_partner_fail_i), .sb_link_ok_i(sb_link_ok_i),
  .port_block_o(port_block_o), .role_o(role_o), .stp_en_o(stp_en_o),
  .sb_master_o(sb_master_o), .sb_port_en_o(sb_port_en_o), .err_led_o(err_led_o),
  .msg_o(msg_o));
`default_nettype wire

// ===== tb/ring_peer_model.sv
// far side: negotiating ring peer, manager presence and standby partner
`timescale 1ns/1ps
`default_nettype none
module ring_peer_model #(
  parameter logic [47:0] SB_MAC = 48'h0200_0000_0000
) (
  input  wire logic        clk_i,
  input  wire logic        adv_i,
  input  wire logic [47:0] adv_mac_i,
  input  wire logic        mgr_i,
  input  wire logic        sb_down_i,
  output logic      [47:0] peer_mac_o,
  output logic             peer_vld_o,
  output logic             mgr_seen_o,
  output logic      [47:0] sb_mac_o,
  output logic             sb_fail_o
);
  // an advert lasts one cycle; outside it the word is inverted so stale data is never usable
  always @(posedge clk_i) begin
    peer_vld_o <= adv_i;
    peer_mac_o <= adv_i ? adv_mac_i : ~adv_mac_i;
  end
  assign mgr_seen_o = mgr_i;
  assign sb_mac_o   = SB_MAC;
  assign sb_fail_o  = sb_down_i;
endmodule : ring_peer_model
`default_nettype wire

// ===== tb/ring_redundancy_role_control_tb_top.sv
// self-checking bench of the ring role block
`timescale 1ns/1ps
`default_nettype none
`include "ring_regs.svh"
module ring_redundancy_role_control_tb_top;
  localparam int unsigned NP   = 24;
  localparam int unsigned NEGO = 20;
  localparam int unsigned WIN  = 50;
  logic          clk, rst, we, re, fault, fr, var_sel, link, mgr, adv, sb_down, pforce;
  logic [7:0]    addr;
  logic [31:0]   wdata, rdata;
  logic [47:0]   adv_mac, peer_mac, sb_mac;
  logic [NP-1:0] pblock, pmask;
  logic [2:0]    role;
  logic          stp, sbm, sbp, led, msg, peer_vld, mgr_seen, sb_fail;
  int            err_count, comparisons, cyc_n;

  ring_redundancy_role_control #(.N_PORTS(NP), .NEGO_CYC(NEGO), .OBS_WIN(WIN)) dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .mgr_seen_i(mgr_seen), .peer_mac_i(peer_mac),
    .peer_mac_vld_i(peer_vld), .obs_fault_i(fault), .factory_reset_i(fr),
    .variant_i(var_sel), .sb_partner_mac_i(sb_mac), .sb_partner_force_i(pforce),
    .sb_partner_fail_i(sb_fail), .sb_link_ok_i(link), .port_block_o(pblock),
    .ring_port_mask_o(pmask), .role_o(role), .stp_en_o(stp), .sb_master_o(sbm),
    .sb_port_en_o(sbp), .err_led_o(led), .msg_o(msg));
  ring_peer_model peer (
    .clk_i(clk), .adv_i(adv), .adv_mac_i(adv_mac), .mgr_i(mgr), .sb_down_i(sb_down),
    .peer_mac_o(peer_mac), .peer_vld_o(peer_vld), .mgr_seen_o(mgr_seen),
    .sb_mac_o(sb_mac), .sb_fail_o(sb_fail));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // the whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [31:0] x);
    return 32'h1 | (32'(m) << `RR_CTRL_MODE_LSB) | x;
  endfunction : ctl

  task automatic t_fixed();
    logic [2:0] md[3] = '{ring_pkg::mode_mrp_client, ring_pkg::mode_propr_client,
                          ring_pkg::mode_propr_manager};
    logic [2:0] rl[3] = '{ring_pkg::role_mrp_client, ring_pkg::role_propr_client,
                          ring_pkg::role_propr_manager};
    logic [31:0] d;
    rd(8'h1c, d);
    chk("unmapped read", 32'h0, d);
    for (int i = 0; i < 3; i++) begin
      wr(`RR_CTRL, ctl(md[i], 32'h0));
      cyc(3);
      chk("fixed role", 32'(rl[i]), 32'(role));
    end
    chk("ring mask", 32'h3, 32'(pmask));
    wr(`RR_MANUAL, 32'h6);
    cyc(3);
    chk("manual on ring ports", 32'h5, 32'(pblock[2:0]));
    wr(`RR_MANUAL, 32'h0);
    $display("fixed roles done");
  endtask : t_fixed

  task automatic t_nego();
    wr(`RR_MAC_LO, 32'h0);
    wr(`RR_MAC_HI, 32'h0100);
    mgr <= 1'b1;
    wr(`RR_CTRL, ctl(ring_pkg::mode_mrp_auto, 32'h0));
    cyc(NEGO / 2);
    chk("role in window", 32'h0, 32'(role));
    cyc(NEGO);
    chk("auto manager", 32'(ring_pkg::role_mrp_manager), 32'(role));
    @(posedge clk) adv <= 1'b1;
    adv_mac <= 48'h00ff_ffff_ffff;
    @(posedge clk) adv <= 1'b0;
    cyc(4);
    chk("lower peer", 32'(ring_pkg::role_mrp_client), 32'(role));
    wr(`RR_CTRL, ctl(ring_pkg::mode_auto, 32'h0));
    cyc(4);
    chk("detect manager", 32'(ring_pkg::role_propr_client), 32'(role));
    @(posedge clk) mgr <= 1'b0;
    $display("negotiation done");
  endtask : t_nego

  task automatic t_obs();
    logic [31:0] c;
    c = ctl(ring_pkg::mode_propr_client, 32'h1 << `RR_CTRL_OBS_EN);
    wr(`RR_CTRL, c);
    cyc(3);
    @(posedge clk) fault <= 1'b1;
    cyc(3);
    chk("fault blocks", 32'h1, 32'(pblock[0]));
    @(posedge clk) fault <= 1'b0;
    cyc(3);
    chk("fault cleared", 32'h0, 32'(pblock[0]));
    cyc(WIN + 5);
    repeat (`RR_OBS_ERR_LIMIT - 1) begin
      @(posedge clk) fault <= 1'b1;
      @(posedge clk) fault <= 1'b0;
    end
    cyc(3);
    chk("below limit", 32'h0, 32'(led));
    @(posedge clk) fault <= 1'b1;
    @(posedge clk) fault <= 1'b0;
    cyc(WIN + 5);
    chk("latched led", 32'h1, 32'(led));
    chk("latched block", 32'h1, 32'(pblock[0]));
    wr(`RR_CTRL, c | (32'h1 << `RR_CTRL_OBS_RESTART));
    cyc(3);
    chk("restart opens", 32'h0, 32'(pblock[0]));
    $display("observer done");
  endtask : t_obs

  task automatic t_sb();
    logic [31:0] c;
    c = ctl(ring_pkg::mode_propr_manager, 32'h1 << `RR_CTRL_SB_EN);
    wr(`RR_CTRL, c);
    link <= 1'b1;
    cyc(4);
    chk("higher partner", 32'h0, 32'(sbm));
    chk("slave idle", 32'h0, 32'(sbp));
    @(posedge clk) sb_down <= 1'b1;
    cyc(3);
    chk("slave takeover", 32'h1, 32'(sbp));
    wr(`RR_CTRL, c | (32'h1 << `RR_CTRL_SB_FORCE));
    cyc(4);
    chk("forced master", 32'h1, 32'(sbm));
    chk("master forwards", 32'h1, 32'(sbp));
    @(posedge clk) pforce <= 1'b1;
    cyc(3);
    chk("both forced", 32'h0, 32'(sbm));
    @(posedge clk) pforce <= 1'b0;
    @(posedge clk) link <= 1'b0;
    cyc(3);
    chk("master link lost", 32'h0, 32'(sbp));
    wr(`RR_CTRL, ctl(ring_pkg::mode_mrp_client, 32'h3 << `RR_CTRL_SB_EN));
    cyc(4);
    chk("standby off in mrp", 32'h0, 32'({sbm, sbp}));
    $display("standby done");
  endtask : t_sb

  task automatic t_factory();
    logic [31:0] d;
    for (int v = 0; v < 2; v++) begin
      wr(`RR_CTRL, 32'h0);
      wr(`RR_PORTS, 32'h00050403);
      var_sel <= v[0];
      @(posedge clk) fr <= 1'b1;
      @(posedge clk) fr <= 1'b0;
      rd(`RR_CTRL, d);
      if (v == 0) chk("v0 ring off stp on", 32'h40, d & 32'h41);
      else chk("v1 ring on", 32'h1, d & 32'h1);
      chk("stp pin", 32'(v == 0), 32'(stp));
      rd(`RR_PORTS, d);
      chk("default ports", 32'h00020100, d);
    end
    $display("factory reset done");
  endtask : t_factory

  initial begin
    {rst, we, re, fault, fr, var_sel, link, mgr, adv, sb_down, pforce} = 11'h400;
    addr = 8'h0;
    wdata = 32'h0;
    adv_mac = 48'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_fixed();
    t_nego();
    t_obs();
    t_sb();
    t_factory();
    print_verdict();
  end
endmodule : ring_redundancy_role_control_tb_top
`default_nettype wire
